// ---- hdl/ext_exec.sv ----
`timescale 1ns/1ps
module ext_exec (
  input  wire logic                      core_clk_in,
  input  wire logic                      rst_b_in,
  input  wire logic                      extended_set_enable_in,
  input  wire logic                      instr_valid_in,
  input  wire logic [15:0]               instr_word_in,
  input  wire logic [ext_exec_pkg::PC_W-1:0] pc_in,
  input  wire logic [7:0]                accumulator_byte_in,
  input  wire logic [7:0]                counter_latch_high_in,
  input  wire logic [4:0]                counter_latch_upper_in,
  input  wire logic [ext_exec_pkg::PC_W-1:0] return_stack_top_in,
  input  wire logic [7:0]                mem_rdata_in,
  input  wire logic                      ptr_wr_in,
  input  wire logic [1:0]                ptr_wr_sel_in,
  input  wire logic [ext_exec_pkg::ADDR_W-1:0] ptr_wr_data_in,
  output      logic [1:0]                phase_out,
  output      logic                      busy_out,
  output      ext_exec_pkg::pc_req_t     pc_load_out,
  output      ext_exec_pkg::pc_req_t     stack_push_out,
  output      ext_exec_pkg::mem_req_t    mem_rd_out,
  output      ext_exec_pkg::mem_req_t    mem_wr_out,
  output      logic [ext_exec_pkg::PTR_NUM-1:0][ext_exec_pkg::ADDR_W-1:0] file_select_pointer_out
);
  import ext_exec_pkg::*;

  // Pointer select and counter concatenation are fixed at these sizes
  if (PTR_NUM != 3 || PC_W != 21) begin : g_bad_size
    $error("ext_exec: pointer or counter width unsupported");
  end

  function automatic logic is_indirect(input logic [ADDR_W-1:0] addr);
    is_indirect = (addr == INDIR_ADDR0) || (addr == INDIR_ADDR1) || (addr == INDIR_ADDR2);
  endfunction : is_indirect

  ////////////////////////////////////////////////////////////////////////////////
  logic                          xen_meta_ff;
  logic                          xen_ff;
  logic [1:0]                    q_ff;
  exec_state_t                   state_ff;
  exec_state_t                   nxt_state;
  decode_t                       op_ff;
  decode_t                       dec_w;
  logic [ADDR_W-1:0]             ptr_ff [PTR_NUM];
  wire  [ADDR_W-1:0]             nxt_ptr [PTR_NUM];
  logic                          src_indir_ff;
  logic                          word2_ok_ff;
  logic [ADDR_W-1:0]             dest_ff;
  logic [7:0]                    data_ff;
  pc_req_t                       nxt_pc_load;
  pc_req_t                       nxt_push;
  mem_req_t                      nxt_rd;
  mem_req_t                      nxt_wr;

  ext_decode u_decode (
    .instr_word_in (instr_word_in),
    .dec_out       (dec_w)
  );

  // Configuration bit is a static pin level, still synchronised
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      xen_meta_ff <= 1'b0;
      xen_ff      <= 1'b0;
    end else begin
      xen_meta_ff <= extended_set_enable_in;
      xen_ff      <= xen_meta_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  wire q1_w     = (q_ff == PH_Q1);
  wire q2_w     = (q_ff == PH_Q2);
  wire q3_w     = (q_ff == PH_Q3);
  wire q4_w     = (q_ff == PH_Q4);
  wire first_w  = (state_ff == S_FETCH);
  wire start_w  = q1_w && first_w && instr_valid_in && xen_ff;

  wire [1:0]        sel_w     = op_ff.add_ret ? SEL_FRAME : op_ff.ptr_sel;
  wire              do_add_w  = q4_w && first_w && (op_ff.add_ptr || op_ff.add_ret);
  wire [ADDR_W-1:0] ptr_sum_w = ptr_ff[sel_w] + {{(ADDR_W-LIT_W){1'b0}}, op_ff.lit};
  wire              ret_w     = q4_w && first_w && op_ff.add_ret;
  wire              push_w    = q3_w && first_w && op_ff.call_acc;
  wire              call_w    = q4_w && first_w && op_ff.call_acc;
  wire [PC_W-1:0]   ret_addr_w    = pc_in + RET_STEP;
  wire [PC_W-1:0]   call_target_w = {counter_latch_upper_in, counter_latch_high_in,
                                     accumulator_byte_in};
  wire [ADDR_W-1:0] src_addr_w = ptr_ff[SEL_FRAME]
                                 + {{(ADDR_W-OFF_W){1'b0}}, op_ff.offset};
  wire              src_indir_w = is_indirect(src_addr_w);
  wire              move_w      = q4_w && first_w && op_ff.move_idx;
  wire              word2_ok_w  = instr_valid_in && (instr_word_in[15:12] == WORD2_PREFIX);

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      S_FETCH: begin
        if (q4_w && (op_ff.add_ret || op_ff.call_acc)) begin
          nxt_state = S_NOP;
        end else if (move_w) begin
          nxt_state = S_MOVE2;
        end
      end
      S_NOP, S_MOVE2: begin
        if (q4_w) begin
          nxt_state = S_FETCH;
        end
      end
      default: nxt_state = S_FETCH;
    endcase
  end

  // Counter, stack and memory requests are driven; accumulator and flags have no path
  always_comb begin
    nxt_pc_load = '0;
    nxt_push    = '0;
    nxt_rd      = '0;
    nxt_wr      = '0;
    if (ret_w) begin
      nxt_pc_load = '{valid: 1'b1, value: return_stack_top_in};
    end else if (call_w) begin
      nxt_pc_load = '{valid: 1'b1, value: call_target_w};
    end
    if (push_w) begin
      nxt_push = '{valid: 1'b1, value: ret_addr_w};
    end
    // No read issued for an indirect source, so no side effects fire
    if (move_w && !src_indir_w) begin
      nxt_rd = '{valid: 1'b1, addr: src_addr_w, data: ZERO_BYTE};
    end
    if (q4_w && state_ff == S_MOVE2 && word2_ok_ff) begin
      nxt_wr = '{valid: 1'b1, addr: dest_ff, data: data_ff};
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      q_ff           <= PH_Q1;
      state_ff       <= S_FETCH;
      phase_out      <= PH_Q1;
      busy_out       <= 1'b0;
      pc_load_out    <= '0;
      stack_push_out <= '0;
      mem_rd_out     <= '0;
      mem_wr_out     <= '0;
    end else begin
      q_ff           <= q_ff + 2'h1;
      state_ff       <= nxt_state;
      phase_out      <= q_ff + 2'h1;
      busy_out       <= (nxt_state != S_FETCH);
      pc_load_out    <= nxt_pc_load;
      stack_push_out <= nxt_push;
      mem_rd_out     <= nxt_rd;
      mem_wr_out     <= nxt_wr;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      op_ff        <= '0;
      src_indir_ff <= 1'b0;
      word2_ok_ff  <= 1'b0;
      dest_ff      <= PTR_RST;
      data_ff      <= ZERO_BYTE;
    end else begin
      if (q1_w && first_w) begin
        op_ff <= start_w ? dec_w : '0;
      end
      if (move_w) begin
        src_indir_ff <= src_indir_w;
      end
      if (q1_w && state_ff == S_MOVE2) begin
        word2_ok_ff <= word2_ok_w;
        dest_ff     <= instr_word_in[ADDR_W-1:0];
      end
      if (q2_w && state_ff == S_MOVE2) begin
        data_ff <= src_indir_ff ? ZERO_BYTE : mem_rdata_in;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  genvar gi;
  for (gi = 0; gi < PTR_NUM; gi++) begin : g_ptr
    // Own update wins over a core write in the same clock
    wire add_hit_w = do_add_w && (sel_w == 2'(gi));
    wire wr_hit_w  = ptr_wr_in && (ptr_wr_sel_in == 2'(gi));
    assign nxt_ptr[gi] = add_hit_w ? ptr_sum_w
                       : wr_hit_w  ? ptr_wr_data_in
                       : ptr_ff[gi];
  end

  // One process owns every pointer flop, so no element has two writers
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ptr_ff                  <= '{default: PTR_RST};
      file_select_pointer_out <= {PTR_NUM{PTR_RST}};
    end else begin
      ptr_ff <= nxt_ptr;
      for (int i = 0; i < PTR_NUM; i++) begin
        file_select_pointer_out[i] <= nxt_ptr[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  logic [1:0] sel_hold;
  assign sel_hold = sel_w;

  ptr_add_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    do_add_w |=> file_select_pointer_out[$past(sel_hold)] == $past(ptr_sum_w))
    else $error("pointer add result wrong");

  add_single_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (do_add_w && op_ff.add_ptr) |=> !busy_out && !pc_load_out.valid)
    else $error("pointer add took more than one cycle");

  ret_frame_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    ret_w |=> file_select_pointer_out[SEL_FRAME] == $past(file_select_pointer_out[SEL_FRAME])
      + {{(ADDR_W-LIT_W){1'b0}}, $past(op_ff.lit)})
    else $error("add-and-return touched wrong pointer");

  ret_load_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    ret_w |=> pc_load_out.valid && pc_load_out.value == $past(return_stack_top_in))
    else $error("return did not load stack top");

  nop_quiet_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (state_ff == S_NOP && !q1_w) |-> !pc_load_out.valid && !stack_push_out.valid
      && !mem_rd_out.valid && !mem_wr_out.valid)
    else $error("activity during idle cycle");

  call_push_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    push_w |=> stack_push_out.valid && stack_push_out.value == $past(ret_addr_w)
      ##1 pc_load_out.valid && pc_load_out.value == $past(call_target_w))
    else $error("call push or target wrong");

  call_busy_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    call_w |=> busy_out [*4] ##1 !busy_out)
    else $error("call second cycle length wrong");

  move_zero_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (move_w && src_indir_w) |-> ##1 !mem_rd_out.valid ##4 (!mem_wr_out.valid
      || mem_wr_out.data == ZERO_BYTE))
    else $error("indirect source not read as zero");

  move_dest_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (q4_w && state_ff == S_MOVE2 && word2_ok_ff) |=> mem_wr_out.valid
      && mem_wr_out.addr == $past(dest_ff))
    else $error("move destination write missing");

endmodule : ext_exec

// ---- hdl/ext_exec_pkg.sv ----
// Overview of operation
// - Add six-bit literal to selected pointer, no flags
// - Select field three means add-and-return
// - Add-and-return adds literal to frame pointer
// - Add-and-return then loads counter from stack
// - Add-and-return second cycle does nothing
// - Recognise call through accumulator opcode
// - Call pushes counter plus two first
// - Call loads counter low from accumulator
// - Call copies latches into counter high, upper
// - Call second cycle idles during target fetch
// - Call leaves accumulator, status, bank untouched
// - Move source is frame pointer plus offset
// - Move destination is second word literal
// - Indirect source address reads as zero
package ext_exec_pkg;

  localparam int          PC_W          = 21;
  localparam int          ADDR_W        = 12;
  localparam int          PTR_NUM       = 3;
  localparam int          LIT_W         = 6;
  localparam int          OFF_W         = 7;

  localparam logic [7:0]  OPC_ADD_PTR   = 8'hE8;
  localparam logic [7:0]  OPC_MOVE_IDX  = 8'hEB;
  localparam logic [15:0] OPC_CALL_ACC  = 16'h0014;
  localparam logic [3:0]  WORD2_PREFIX  = 4'hF;
  localparam logic [1:0]  SEL_RETURN    = 2'h3;
  localparam logic [1:0]  SEL_FRAME     = 2'h2;
  localparam logic [PC_W-1:0] RET_STEP  = 21'h000002;

  localparam logic [1:0]  PH_Q1         = 2'h0;
  localparam logic [1:0]  PH_Q2         = 2'h1;
  localparam logic [1:0]  PH_Q3         = 2'h2;
  localparam logic [1:0]  PH_Q4         = 2'h3;

  // Indirect access register addresses
  localparam logic [ADDR_W-1:0] INDIR_ADDR0 = 12'hFF0;
  localparam logic [ADDR_W-1:0] INDIR_ADDR1 = 12'hFF1;
  localparam logic [ADDR_W-1:0] INDIR_ADDR2 = 12'hFF2;

  localparam logic [ADDR_W-1:0] PTR_RST     = 12'h000;
  localparam logic [7:0]        ZERO_BYTE   = 8'h00;

  typedef enum logic [1:0] {S_FETCH, S_NOP, S_MOVE2} exec_state_t;

  typedef struct packed {
    logic             add_ptr;
    logic             add_ret;
    logic             call_acc;
    logic             move_idx;
    logic [1:0]       ptr_sel;
    logic [LIT_W-1:0] lit;
    logic [OFF_W-1:0] offset;
  } decode_t;

  typedef struct packed {
    logic              valid;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
  } mem_req_t;

  typedef struct packed {
    logic            valid;
    logic [PC_W-1:0] value;
  } pc_req_t;

endpackage : ext_exec_pkg

// ---- hdl/ext_decode.sv ----
`timescale 1ns/1ps
module ext_decode (
  input  wire logic [15:0]           instr_word_in,
  output      ext_exec_pkg::decode_t dec_out
);
  import ext_exec_pkg::*;

  wire       add_group_w = (instr_word_in[15:8] == OPC_ADD_PTR);
  wire [1:0] sel_w       = instr_word_in[7:6];

  assign dec_out.add_ptr  = add_group_w && (sel_w != SEL_RETURN);
  assign dec_out.add_ret  = add_group_w && (sel_w == SEL_RETURN);
  assign dec_out.call_acc = (instr_word_in == OPC_CALL_ACC);
  assign dec_out.move_idx = (instr_word_in[15:8] == OPC_MOVE_IDX)
                            && !instr_word_in[OFF_W];
  assign dec_out.ptr_sel  = sel_w;
  assign dec_out.lit      = instr_word_in[LIT_W-1:0];
  assign dec_out.offset   = instr_word_in[OFF_W-1:0];

endmodule : ext_decode

// ---- verif/ext_partner.sv ----
`timescale 1ns/1ps
module ext_partner
  import ext_exec_pkg::*;
#(
  parameter logic [PC_W-1:0] TOP_RST = 21'h0ABCD
) (
  input  wire logic            core_clk_in,
  input  wire logic            rst_b_in,
  input  wire mem_req_t        mem_rd_in,
  input  wire pc_req_t         stack_push_in,
  output      logic [7:0]      mem_rdata_out,
  output      logic [PC_W-1:0] return_stack_top_out
);
  logic [1:0] hold_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Read data holds two clocks, then toggles so stale data is never mistaken
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mem_rdata_out        <= 8'h00;
      hold_ff              <= 2'h0;
      return_stack_top_out <= TOP_RST;
    end else begin
      if (mem_rd_in.valid) begin
        mem_rdata_out <= mem_rd_in.addr[7:0] ^ 8'h5A;
        hold_ff       <= 2'h2;
      end else if (hold_ff != 2'h0) begin
        hold_ff <= hold_ff - 2'h1;
      end else begin
        mem_rdata_out <= ~mem_rdata_out;
      end
      if (stack_push_in.valid) begin
        return_stack_top_out <= stack_push_in.value;
      end
    end
  end
endmodule : ext_partner

// ---- verif/extended_pointer_instr_exec_bench.sv ----
`timescale 1ns/1ps
module extended_pointer_instr_exec_bench;
  import ext_exec_pkg::*;
  localparam logic [PC_W-1:0] TOP_RST = 21'h0ABCD;
  typedef struct packed {
    logic [11:0] pre;
    logic [15:0] word;
    logic [1:0]  sel;
    logic [11:0] exp;
    logic        ret;
  } row_t;
  row_t                             rows [4];
  logic                             core_clk, rst_b, ext_en, instr_valid, ptr_wr, busy;
  logic [15:0]                      instr_word;
  logic [PC_W-1:0]                  pc, rs_top;
  logic [7:0]                       acc, lat_hi, rdata;
  logic [4:0]                       lat_up;
  logic [1:0]                       ptr_sel, phase;
  logic [11:0]                      ptr_data;
  pc_req_t                          pc_load, push;
  mem_req_t                         mem_rd, mem_wr;
  logic [PTR_NUM-1:0][ADDR_W-1:0]   ptrs;
  int                               error_cnt = 0;
  int                               compares = 0;
  int                               cycles = 0;

  ext_exec i_ext_exec (.core_clk_in(core_clk), .rst_b_in(rst_b), .extended_set_enable_in(ext_en),
    .instr_valid_in(instr_valid), .instr_word_in(instr_word), .pc_in(pc),
    .accumulator_byte_in(acc), .counter_latch_high_in(lat_hi), .counter_latch_upper_in(lat_up),
    .return_stack_top_in(rs_top), .mem_rdata_in(rdata), .ptr_wr_in(ptr_wr),
    .ptr_wr_sel_in(ptr_sel), .ptr_wr_data_in(ptr_data), .phase_out(phase), .busy_out(busy),
    .pc_load_out(pc_load), .stack_push_out(push), .mem_rd_out(mem_rd), .mem_wr_out(mem_wr),
    .file_select_pointer_out(ptrs));
  ext_partner #(.TOP_RST(TOP_RST)) i_ext_partner (.core_clk_in(core_clk), .rst_b_in(rst_b),
    .mem_rd_in(mem_rd), .stack_push_in(push), .mem_rdata_out(rdata),
    .return_stack_top_out(rs_top));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      close_out();
    end
  end

  task automatic close_out();
    if (error_cnt == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : step

  // Waits for a Q1 edge; caller must stand just after an edge
  task automatic issue(input logic [15:0] w);
    while (phase !== 2'h0) step(1);
    instr_word  = w;
    instr_valid = 1'b1;
    step(1);
    instr_valid = 1'b0;
  endtask : issue

  task automatic setp(input logic [1:0] s, input logic [11:0] v);
    ptr_wr   = 1'b1;
    ptr_sel  = s;
    ptr_data = v;
    step(1);
    ptr_wr = 1'b0;
  endtask : setp

  task automatic idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 20) begin
      step(1);
      n++;
    end
    check("busy_end", busy, 1'b0);
  endtask : idle

  task automatic move(input logic [15:0] w1, input logic [11:0] src, input logic rd,
                      input logic [11:0] dst, input logic [7:0] d);
    int n;
    issue(w1);
    step(3);
    check("mov_rd", mem_rd.valid, rd);
    if (rd) check("mov_src", mem_rd.addr, src);
    instr_word  = {4'hF, dst};
    instr_valid = 1'b1;
    step(1);
    instr_valid = 1'b0;
    n = 0;
    while (mem_wr.valid !== 1'b1 && n < 8) begin
      step(1);
      n++;
    end
    check("mov_wr", {mem_wr.valid, mem_wr.addr, mem_wr.data}, {1'b1, dst, d});
    idle();
  endtask : move

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_b = 1'b0;
    ext_en = 1'b1;
    instr_valid = 1'b0;
    instr_word = 16'h0000;
    pc = 21'h000100;
    acc = 8'h06;
    lat_hi = 8'h10;
    lat_up = 5'h01;
    ptr_wr = 1'b0;
    ptr_sel = 2'h0;
    ptr_data = 12'h000;
    rows[0] = '{12'h3FF, 16'hE8A3, 2'h2, 12'h422, 1'b0};
    rows[1] = '{12'h000, 16'hE83F, 2'h0, 12'h03F, 1'b0};
    rows[2] = '{12'hFFF, 16'hE841, 2'h1, 12'h000, 1'b0};
    rows[3] = '{12'h3FF, 16'hE8E3, 2'h2, 12'h422, 1'b1};
    step(10);
    check("rst_out", {phase, busy, pc_load.valid, mem_wr.valid, ptrs[2]}, 17'h00000);
    rst_b = 1'b1;
    step(1);
    check("phase_run", phase, 2'h1);
    step(3);
    foreach (rows[i]) begin
      setp(rows[i].sel, rows[i].pre);
      issue(rows[i].word);
      step(3);
      check("pointer", ptrs[rows[i].sel], rows[i].exp);
      check("ret_valid", pc_load.valid, rows[i].ret);
      if (rows[i].ret) check("ret_pc", pc_load.value, TOP_RST);
      check("ret_busy", busy, rows[i].ret);
      idle();
    end
    // Disabled set must leave the frame pointer alone
    ext_en = 1'b0;
    step(3);
    issue(16'hE8A3);
    step(4);
    check("ext_off", ptrs[2], 12'h422);
    ext_en = 1'b1;
    step(3);
    issue(OPC_CALL_ACC);
    step(2);
    check("push", push, {1'b1, pc + 21'h000002});
    step(1);
    check("call_load", pc_load, {1'b1, lat_up, lat_hi, acc});
    check("call_busy", busy, 1'b1);
    issue(16'hE8A1);
    idle();
    step(4);
    check("busy_drop", {ptrs[2], mem_wr.valid}, {12'h422, 1'b0});
    setp(2'h2, 12'h080);
    move(16'hEB05, 12'h085, 1'b1, 12'h123, 8'h85 ^ 8'h5A);
    setp(2'h2, 12'hFEB);
    move(16'hEB05, 12'hFF0, 1'b0, 12'h456, 8'h00);
    // Reset in mid-call must clear pulses and the frame pointer at once
    issue(OPC_CALL_ACC);
    step(2);
    rst_b = 1'b0;
    #1;
    check("rst_mid", {phase, busy, push.valid, pc_load.valid, ptrs[2]}, 17'h00000);
    step(2);
    rst_b = 1'b1;
    step(1);
    check("phase_again", phase, 2'h1);
    issue(16'hE8A3);
    step(3);
    check("add_again", {ptrs[2], busy}, {12'h023, 1'b0});
    close_out();
  end
endmodule : extended_pointer_instr_exec_bench
